// ==== core/ctcr_map.svh ====
`ifndef CTCR_MAP_SVH
`define CTCR_MAP_SVH
// ==========================================
// register offsets
`define CTCR_TIMER_CTRL_ADDR 8'h04
`define CTCR_VOLT_CTRL_ADDR 8'h05
// ==========================================
// reset values and voltage control write mask
`define CTCR_TIMER_CTRL_RST 8'hB1
`define CTCR_VOLT_CTRL_RST 8'h80
`define CTCR_VOLT_CTRL_WMASK 8'hF0
// ==========================================
// field positions, timer control
`define CTCR_FAST_TMR_HI 7
`define CTCR_FAST_TMR_LO 6
`define CTCR_TMR_ON_BIT 5
`define CTCR_CURVE_BIT 4
`define CTCR_CHG_RST_BIT 3
`define CTCR_TERM_OFF_BIT 2
`define CTCR_FREEZE_BIT 1
`define CTCR_CHG_ON_BIT 0
// ==========================================
// field positions, voltage control
`define CTCR_SLOW_BIT 7
`define CTCR_PRE_THR_BIT 6
`define CTCR_VREG_HI 5
`define CTCR_VREG_LO 4
// ==========================================
// timing: limits in minutes, one tick per minute
`define CTCR_FAST_4H_MIN 16'd240
`define CTCR_FAST_5H_MIN 16'd300
`define CTCR_FAST_6H_MIN 16'd360
`define CTCR_FAST_8H_MIN 16'd480
`define CTCR_PRE_MIN_DEF 16'd30
`define CTCR_CLK_HZ 100000000
`define CTCR_MINUTE_S 60
`endif

// ==== core/ctcr_pkg.sv ====
package ctcr_pkg;
  typedef enum logic [1:0] {
    CTCR_IDLE = 2'b00,
    CTCR_PRE = 2'b01,
    CTCR_FAST = 2'b10,
    CTCR_DONE = 2'b11
  } ctcr_phase_t;
  typedef logic [7:0] ctcr_byte_t;
endpackage

// ==== core/ctcr_tick_gen.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ctcr_map.svh"
// ==========================================
// timer tick generator with half-rate option
module ctcr_tick_gen #(
  parameter longint unsigned TICK_CYCLES = 64'(`CTCR_CLK_HZ) * `CTCR_MINUTE_S // cycles per timer minute
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic run,
  input wire logic half_rate,
  output logic tick
);
  logic [39:0] cnt_q, cnt_d;
  logic odd_q, odd_d;
  logic tick_q, tick_d;
  assign tick = tick_q;
  // prescaler; when halved only every second wrap ticks
  always_comb begin
    cnt_d = cnt_q;
    odd_d = odd_q;
    tick_d = 1'b0;
    if (run) begin
      if (cnt_q >= 40'(TICK_CYCLES - 1)) begin
        cnt_d = '0;
        odd_d = ~odd_q;
        tick_d = ~half_rate | odd_q;
      end else begin
        cnt_d = cnt_q + 40'd1;
      end
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      odd_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      odd_q <= odd_d;
      tick_q <= tick_d;
    end
  end
endmodule
`default_nettype wire

// ==== core/ctcr_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ctcr_map.svh"
module ctcr_regs #(
  parameter longint unsigned TICK_CYCLES = 64'(`CTCR_CLK_HZ) * `CTCR_MINUTE_S,
  parameter logic [15:0] PRE_LIMIT_MIN = `CTCR_PRE_MIN_DEF
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire ctcr_pkg::ctcr_byte_t wdata,
  output ctcr_pkg::ctcr_byte_t rdata,
  input wire logic battery_low,
  input wire logic taper_reached,
  input wire logic thermal_regulation_in,
  input wire logic input_power_loop_active,
  output logic charger_run,
  output logic charger_in_reset,
  output logic fast_phase,
  output logic thermistor_curve_sel,
  output logic precharge_threshold_sel,
  output logic [1:0] regulation_voltage_sel,
  output logic fast_charge_timeout_flag,
  output logic precharge_timeout_flag,
  output logic thermal_regulation_flag
);
  import ctcr_pkg::*;
  // ==========================================
  // register bytes
  ctcr_byte_t tctl_q, tctl_d, vctl_q, vctl_d, rdata_q, rdata_d;
  always_comb begin
    tctl_d = tctl_q;
    vctl_d = vctl_q;
    if (wr_en && addr == `CTCR_TIMER_CTRL_ADDR) begin
      tctl_d = wdata;
    end
    if (wr_en && addr == `CTCR_VOLT_CTRL_ADDR) begin
      vctl_d = wdata & `CTCR_VOLT_CTRL_WMASK; // low nibble reserved, reads zero
    end
  end
  // read data registered so rdata comes from a flop
  always_comb begin
    rdata_d = rdata_q;
    if (rd_en) begin
      case (addr)
        `CTCR_TIMER_CTRL_ADDR: rdata_d = tctl_q;
        `CTCR_VOLT_CTRL_ADDR: rdata_d = vctl_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tctl_q <= `CTCR_TIMER_CTRL_RST;
      vctl_q <= `CTCR_VOLT_CTRL_RST;
      rdata_q <= 8'h00;
    end else begin
      tctl_q <= tctl_d;
      vctl_q <= vctl_d;
      rdata_q <= rdata_d;
    end
  end
  assign rdata = rdata_q;
  // ==========================================
  // field decode
  logic tmr_on, chg_on, chg_rst, term_off, freeze, slow_en;
  assign tmr_on = tctl_q[`CTCR_TMR_ON_BIT];
  assign chg_on = tctl_q[`CTCR_CHG_ON_BIT];
  assign chg_rst = tctl_q[`CTCR_CHG_RST_BIT];
  assign term_off = tctl_q[`CTCR_TERM_OFF_BIT];
  assign freeze = tctl_q[`CTCR_FREEZE_BIT];
  assign slow_en = vctl_q[`CTCR_SLOW_BIT];
  // fast timer limit in minutes
  function automatic logic [15:0] fast_limit(input logic [1:0] code);
    case (code)
      2'b00: fast_limit = `CTCR_FAST_4H_MIN;
      2'b01: fast_limit = `CTCR_FAST_5H_MIN;
      2'b10: fast_limit = `CTCR_FAST_6H_MIN;
      default: fast_limit = `CTCR_FAST_8H_MIN;
    endcase
  endfunction
  // ==========================================
  // charge phase and timers
  ctcr_phase_t phase_q, phase_d;
  logic [15:0] elapsed_q, elapsed_d;
  logic ftout_q, ftout_d, ptout_q, ptout_d;
  logic tick, timers_run, halt;
  assign halt = ~chg_on | chg_rst;
  assign timers_run = tmr_on & ~freeze & ~halt &
    (phase_q == CTCR_PRE || phase_q == CTCR_FAST);
  ctcr_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clock(clock),
    .rst_n(rst_n),
    .run(timers_run),
    .half_rate(slow_en & (thermal_regulation_in | input_power_loop_active)),
    .tick(tick)
  );
  always_comb begin
    phase_d = phase_q;
    elapsed_d = elapsed_q;
    ftout_d = ftout_q;
    ptout_d = ptout_q;
    if (halt) begin
      // restart from zero elapsed time and clear timeouts
      phase_d = CTCR_IDLE;
      elapsed_d = '0;
      ftout_d = 1'b0;
      ptout_d = 1'b0;
    end else begin
      case (phase_q)
        CTCR_IDLE: begin
          phase_d = battery_low ? CTCR_PRE : CTCR_FAST;
          elapsed_d = '0;
        end
        CTCR_PRE: begin
          if (!battery_low) begin
            phase_d = CTCR_FAST;
            elapsed_d = '0;
          end else if (timers_run && tick) begin
            if (elapsed_q + 16'd1 >= PRE_LIMIT_MIN) begin
              ptout_d = 1'b1;
              phase_d = CTCR_DONE;
            end else begin
              elapsed_d = elapsed_q + 16'd1;
            end
          end
        end
        CTCR_FAST: begin
          if (taper_reached && !term_off) begin
            phase_d = CTCR_DONE;
          end else if (timers_run && tick) begin
            if (elapsed_q + 16'd1 >= fast_limit(tctl_q[`CTCR_FAST_TMR_HI:`CTCR_FAST_TMR_LO])) begin
              ftout_d = 1'b1;
              phase_d = CTCR_DONE;
            end else begin
              elapsed_d = elapsed_q + 16'd1;
            end
          end
        end
        CTCR_DONE: phase_d = CTCR_DONE;
        default: phase_d = CTCR_IDLE;
      endcase
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= CTCR_IDLE;
      elapsed_q <= '0;
      ftout_q <= 1'b0;
      ptout_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      elapsed_q <= elapsed_d;
      ftout_q <= ftout_d;
      ptout_q <= ptout_d;
    end
  end
  // ==========================================
  // registered outputs
  logic run_q, rst_q, fph_q, curve_q, pthr_q, thermal_regulation_flag_q;
  logic [1:0] vreg_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0;
      rst_q <= 1'b0;
      fph_q <= 1'b0;
      curve_q <= 1'b1;
      pthr_q <= 1'b0;
      vreg_q <= 2'b00;
      thermal_regulation_flag_q <= 1'b0;
    end else begin
      run_q <= ~halt & (phase_d == CTCR_PRE || phase_d == CTCR_FAST);
      rst_q <= chg_rst;
      fph_q <= phase_d == CTCR_FAST;
      curve_q <= tctl_q[`CTCR_CURVE_BIT];
      pthr_q <= vctl_q[`CTCR_PRE_THR_BIT];
      vreg_q <= vctl_q[`CTCR_VREG_HI:`CTCR_VREG_LO];
      thermal_regulation_flag_q <= thermal_regulation_in;
    end
  end
  assign charger_run = run_q;
  assign charger_in_reset = rst_q;
  assign fast_phase = fph_q;
  assign thermistor_curve_sel = curve_q;
  assign precharge_threshold_sel = pthr_q;
  assign regulation_voltage_sel = vreg_q;
  assign fast_charge_timeout_flag = ftout_q;
  assign precharge_timeout_flag = ptout_q;
  assign thermal_regulation_flag = thermal_regulation_flag_q;
endmodule
`default_nettype wire

// ==== tb/ctcr_regs_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// port checks
module ctcr_regs_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire ctcr_pkg::ctcr_byte_t wdata,
  input wire ctcr_pkg::ctcr_byte_t rdata,
  input wire logic charger_run,
  input wire logic charger_in_reset,
  input wire logic [1:0] regulation_voltage_sel,
  input wire logic fast_charge_timeout_flag,
  input wire logic precharge_timeout_flag
);
  import ctcr_pkg::*;
  logic w4, w5;
  // writes reach the outputs one edge after they are taken, so checks sample them two edges on
  assign w4 = wr_en && addr == 8'h04;
  assign w5 = wr_en && addr == 8'h05;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  reset_mirror_a: assert property (
    w4 |-> ##2 charger_in_reset == $past(wdata[3], 2)) else $error("reset mirror wrong");
  vreg_write_a: assert property (
    w5 |-> ##2 regulation_voltage_sel == $past(wdata[5:4], 2)) else $error("voltage select wrong");
  charger_off_a: assert property (
    w4 && !wdata[0] |-> ##2 !charger_run) else $error("charger still on");
  held_reset_a: assert property (
    charger_in_reset |-> !charger_run) else $error("charger runs in reset");
  unmapped_read_a: assert property (
    rd_en && addr != 8'h04 && addr != 8'h05 |=> rdata == 8'h00) else $error("unmapped read");
  reserved_zero_a: assert property (
    rd_en && addr == 8'h05 |=> rdata[3:0] == 4'h0) else $error("reserved bits set");
  timeout_stop_a: assert property (
    $rose(fast_charge_timeout_flag || precharge_timeout_flag) |-> ##[0:2] !charger_run) else $error("no stop");
  restart_clear_a: assert property (
    charger_in_reset |-> ##[0:2] !precharge_timeout_flag) else $error("flag kept");
  cover property (precharge_timeout_flag);
  cover property (fast_charge_timeout_flag);
  cover property (charger_in_reset ##1 !charger_in_reset);
endmodule
bind ctcr_regs ctcr_regs_chk chk_u (.clock(clock), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
  .wdata(wdata), .rdata(rdata), .charger_run(charger_run), .charger_in_reset(charger_in_reset),
  .regulation_voltage_sel(regulation_voltage_sel), .fast_charge_timeout_flag(fast_charge_timeout_flag),
  .precharge_timeout_flag(precharge_timeout_flag));
`default_nettype wire

// ==== tb/ctcr_host.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// host on the register port
module ctcr_host (
  input wire logic clock,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  // idle port at time zero
  initial begin
    wr_en = 1'h0;
    rd_en = 1'h0;
    addr = 8'hFF;
    wdata = 8'h00;
  end
  // data inverted once taken, so stale bytes never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_en <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr_en <= 1'h0;
    wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    rd_en <= 1'h1;
    addr <= a;
    @(posedge clock);
    rd_en <= 1'h0;
    // read data stands until the next read, so the edge shows it settled
    @(posedge clock);
    d = rdata;
  endtask
endmodule
`default_nettype wire

// ==== tb/test_charger_timer_config_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// bench
module test_charger_timer_config_regs;
  import ctcr_pkg::*;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic batt = 1'h0;
  logic taper = 1'h0;
  logic therm = 1'h0;
  logic loop_act = 1'h0;
  logic wr_en, rd_en, run, in_rst, fph, curve, pre_sel, fflag, pflag, tflag;
  logic [7:0] addr, wdata, rdata, v;
  logic [1:0] vsel;
  int errors = 0;
  int checks_done = 0;
  ctcr_host host_u (.clock(clock), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata));
  ctcr_regs #(.TICK_CYCLES(4), .PRE_LIMIT_MIN(16'h0002)) dut_u (.clock(clock), .rst_n(rst_n), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata), .battery_low(batt), .taper_reached(taper),
    .thermal_regulation_in(therm), .input_power_loop_active(loop_act), .charger_run(run), .charger_in_reset(in_rst),
    .fast_phase(fph), .thermistor_curve_sel(curve), .precharge_threshold_sel(pre_sel),
    .regulation_voltage_sel(vsel), .fast_charge_timeout_flag(fflag), .precharge_timeout_flag(pflag),
    .thermal_regulation_flag(tflag));
  // 100 MHz clock
  initial begin
    forever #5 clock = ~clock;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // set the reset bit, check it holds the charger off, then load the new setting
  task automatic restart(input logic [7:0] cfg);
    host_u.wr(8'h04, 8'h08);
    repeat (2) @(posedge clock);
    chk({6'h0, in_rst, run}, 8'h02);
    host_u.wr(8'h04, cfg);
  endtask
  // main sequence; outputs are read at the edge, so they show settled values
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'h1;
    host_u.rd(8'h04, v);
    chk(v, 8'hB1);
    host_u.rd(8'h05, v);
    chk(v, 8'h80);
    chk({5'h0, fph, run, curve}, 8'h07);
    host_u.rd(8'h09, v);
    chk(v, 8'h00);
    for (int i = 0; i < 4; i++) begin
      host_u.wr(8'h05, {2'h1, i[1:0], 4'hF});
      host_u.rd(8'h05, v);
      chk(v, {2'h1, i[1:0], 4'h0});
      chk({5'h0, vsel, pre_sel}, {5'h0, i[1:0], 1'h1});
    end
    $display("test registers done");
    batt <= 1'h1;
    restart(8'h21);
    repeat (2) @(posedge clock);
    chk({5'h0, in_rst, curve, pflag}, 8'h00);
    repeat (40) @(posedge clock);
    chk({5'h0, fflag, pflag, run}, 8'h02);
    batt <= 1'h0;
    restart(8'h25);
    taper <= 1'h1;
    repeat (20) @(posedge clock);
    chk({5'h0, fph, run, pflag}, 8'h06);
    host_u.wr(8'h04, 8'h21);
    repeat (3) @(posedge clock);
    chk({6'h0, fph, run}, 8'h00);
    taper <= 1'h0;
    restart(8'h23);
    repeat (1100) @(posedge clock);
    chk({7'h0, fflag}, 8'h00);
    host_u.wr(8'h04, 8'h01);
    repeat (1100) @(posedge clock);
    chk({7'h0, fflag}, 8'h00);
    host_u.wr(8'h04, 8'h21);
    repeat (1100) @(posedge clock);
    chk({5'h0, fflag, pflag, run}, 8'h04);
    $display("test timer gating done");
    host_u.wr(8'h05, 8'h80);
    loop_act <= 1'h1;
    restart(8'h21);
    repeat (1300) @(posedge clock);
    chk({4'h0, vsel, pre_sel, fflag}, 8'h00);
    repeat (800) @(posedge clock);
    chk({5'h0, fflag, pflag, run}, 8'h04);
    loop_act <= 1'h0;
    therm <= 1'h1;
    restart(8'h21);
    repeat (1300) @(posedge clock);
    chk({6'h0, tflag, fflag}, 8'h02);
    host_u.wr(8'h05, 8'h00);
    restart(8'h21);
    repeat (1100) @(posedge clock);
    chk({6'h0, tflag, fflag}, 8'h03);
    $display("test slowdown done");
    test_done();
  end
  // hang guard
  initial begin
    #200us;
    errors++;
    test_done();
  end
endmodule
`default_nettype wire
